//--- omra_regs.vh
/*
 * Constants of the on-chip memory map and RAM access block: APB offsets,
 * control and status bit positions, reset values and address regions.
 * Assumes it is included by bare name into the block's design file.
 */
// How it works
// - decode program, local data, I/O and global data spaces separately
// - data page 0 holds 96 memory-mapped words, core and I/O port words
// - memory-mapped words are read and written like any data word
// - fetch, operand read and operand write all served in one cycle
// - dual-access RAM is blocks of 512, 512 and 32 words, 16 bits
// - second and third dual blocks are data; first follows software bit
// - dual RAM gives 1056 data words or 544 data plus 512 program
// - operand read of one instruction overlaps previous one's write
// - dual RAM takes read and write in one cycle without stalling
// - single-access RAM maps as data, program, or both by software
// - single-access RAM is 1K blocks placed contiguously
// - one access per single block per cycle; different blocks parallel
// - conflicts on one single block raise not-ready, served one a cycle
// - in both-spaces mode fetch plus data access to one block takes two
// - strap sampled low at reset maps the on-chip ROM into program space
// - ROM not selected at reset means fetching starts off-chip
// - setting the microprocessor mode bit removes ROM from program map
// - protect bit blocks on-chip access by externally fetched code
`ifndef OMRA_REGS_VH
`define OMRA_REGS_VH

// ---------------------------------------------------------------
// apb register offsets and bits
// ---------------------------------------------------------------
`define OMRA_CTRL_OFF 12'h000
`define OMRA_STAT_OFF 12'h004
`define OMRA_CTRL_CNF 0
`define OMRA_CTRL_SAMAP_LO 1
`define OMRA_CTRL_MP 3
`define OMRA_CTRL_PROT 4
`define OMRA_CTRL_RESET 5'h08
`define OMRA_STAT_NR 0
`define OMRA_STAT_ROM 1
`define OMRA_STAT_VIOL 2
`define OMRA_STAT_STRAP 3

// ---------------------------------------------------------------
// single-access map modes and data space codes
// ---------------------------------------------------------------
`define OMRA_SA_DATA 2'h0
`define OMRA_SA_PROG 2'h1
`define OMRA_SA_BOTH 2'h2
`define OMRA_SP_LOCAL 2'h0
`define OMRA_SP_IO 2'h1
`define OMRA_SP_GLOBAL 2'h2

// ---------------------------------------------------------------
// regions and address tags
// ---------------------------------------------------------------
`define OMRA_RG_EXT 4'h0
`define OMRA_RG_MMR 4'h1
`define OMRA_RG_B0 4'h2
`define OMRA_RG_B1 4'h3
`define OMRA_RG_B2 4'h4
`define OMRA_RG_SA 4'h5
`define OMRA_RG_ROM 4'h6
`define OMRA_RG_IO 4'h7
`define OMRA_RG_GLB 4'h8
`define OMRA_MMR_TOP 16'h0060
`define OMRA_B2_TAG 11'h003
`define OMRA_B0D_TAG 7'h01
`define OMRA_B1_TAG 7'h02
`define OMRA_B0P_TAG 7'h7F
`define OMRA_SA_TAG 5'h01
`define OMRA_ROM_TAG 5'h00
`define OMRA_PROCESSOR_MODE_STATUS_REG_IDX 7'h07
`define OMRA_ROM_FILL 16'h5A3C

`endif

//--- omra_mem_map.v
/*
 * On-chip memory map and RAM access: space decode, memory-mapped page,
 * dual-access blocks, two 1K single-access blocks with conflict
 * serialisation, boot ROM mapping and protection, plus an APB slave.
 * Assumes the core holds its requests unchanged while not-ready is high.
 */
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "omra_regs.vh"

module omra_mem_map (
    // clock and reset
    input wire sys_clk_i,
    input wire nrst_i,
    // reset strap
    input wire microprocessor_mode_select_i,
    // instruction fetch
    input wire pf_req_i,
    input wire [15:0] pf_addr_i,
    // operand read
    input wire dr_req_i,
    input wire [15:0] dr_addr_i,
    input wire [1:0] dr_space_i,
    // operand write
    input wire dw_req_i,
    input wire [15:0] dw_addr_i,
    input wire [1:0] dw_space_i,
    input wire [15:0] dw_data_i,
    // origin of the instruction issuing the data accesses
    input wire ext_origin_i,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // answers to the core
    output reg [15:0] pf_data_o,
    output reg [15:0] dr_data_o,
    output reg not_ready_o,
    // off-chip selects
    output reg ext_prog_sel_o,
    output reg ext_data_sel_o,
    output reg io_sel_o,
    output reg global_sel_o,
    output reg boot_from_ext_o
);

// ---------------------------------------------------------------
// storage and control state
// ---------------------------------------------------------------
reg [15:0] mmr_mem [0:95];
reg [15:0] b0_mem [0:511];
reg [15:0] b1_mem [0:511];
reg [15:0] b2_mem [0:31];
reg [15:0] sa_mem [0:2047];
reg [4:0] ctrl_reg;
reg viol_reg;
reg strap_done_reg;
reg strap_reg;
reg [2:0] done_reg;
reg [2:0] done_next;

// ---------------------------------------------------------------
// space decode
// ---------------------------------------------------------------
// region of an address; prog selects program space
function [3:0] dec;
    input [15:0] a;
    input prog;
    input [1:0] sp;
    input [4:0] c;
    begin
        dec = `OMRA_RG_EXT;
        if (prog) begin
            if (c[`OMRA_CTRL_CNF] && a[15:9] == `OMRA_B0P_TAG)
                dec = `OMRA_RG_B0;
            else if (!c[`OMRA_CTRL_MP] && a[15:11] == `OMRA_ROM_TAG)
                dec = `OMRA_RG_ROM;
            else if (a[15:11] == `OMRA_SA_TAG &&
                     c[2:1] != `OMRA_SA_DATA)
                dec = `OMRA_RG_SA;
        end else if (sp == `OMRA_SP_IO) begin
            dec = `OMRA_RG_IO;
        end else if (sp == `OMRA_SP_GLOBAL && a[15]) begin
            dec = `OMRA_RG_GLB;
        end else if (a < `OMRA_MMR_TOP) begin
            dec = `OMRA_RG_MMR;
        end else if (a[15:5] == `OMRA_B2_TAG) begin
            dec = `OMRA_RG_B2;
        end else if (!c[`OMRA_CTRL_CNF] && a[15:9] == `OMRA_B0D_TAG) begin
            dec = `OMRA_RG_B0;
        end else if (a[15:9] == `OMRA_B1_TAG) begin
            dec = `OMRA_RG_B1;
        end else if (a[15:11] == `OMRA_SA_TAG &&
                     c[2:1] != `OMRA_SA_PROG) begin
            dec = `OMRA_RG_SA;
        end
    end
endfunction

// word held at a region and address
function [15:0] rdw;
    input [3:0] r;
    input [15:0] a;
    begin
        case (r)
            `OMRA_RG_MMR: begin
                if (a[6:0] == `OMRA_PROCESSOR_MODE_STATUS_REG_IDX)
                    rdw = {11'h000, ctrl_reg};
                else
                    rdw = mmr_mem[a[6:0]];
            end
            `OMRA_RG_B0: rdw = b0_mem[a[8:0]];
            `OMRA_RG_B1: rdw = b1_mem[a[8:0]];
            `OMRA_RG_B2: rdw = b2_mem[a[4:0]];
            `OMRA_RG_SA: rdw = sa_mem[a[10:0]];
            `OMRA_RG_ROM: rdw = `OMRA_ROM_FILL ^ {5'h00, a[10:0]};
            default: rdw = 16'h0000;
        endcase
    end
endfunction

function onchip;
    input [3:0] r;
    begin
        onchip = (r != `OMRA_RG_EXT) && (r != `OMRA_RG_IO) &&
                 (r != `OMRA_RG_GLB);
    end
endfunction

wire [3:0] rg_f = dec(pf_addr_i, 1'b1, `OMRA_SP_LOCAL, ctrl_reg);
wire [3:0] rg_r = dec(dr_addr_i, 1'b0, dr_space_i, ctrl_reg);
wire [3:0] rg_w = dec(dw_addr_i, 1'b0, dw_space_i, ctrl_reg);

// ---------------------------------------------------------------
// arbitration of the single-access blocks
// ---------------------------------------------------------------
// requests not yet performed in the current held group
wire act_f = pf_req_i & ~done_reg[0];
wire act_r = dr_req_i & ~done_reg[1];
wire act_w = dw_req_i & ~done_reg[2];
// data accesses from externally fetched code are blocked on-chip
wire prot_r = ctrl_reg[`OMRA_CTRL_PROT] & ext_origin_i & onchip(rg_r);
wire prot_w = ctrl_reg[`OMRA_CTRL_PROT] & ext_origin_i & onchip(rg_w);
wire sa_f = act_f & (rg_f == `OMRA_RG_SA);
wire sa_r = act_r & (rg_r == `OMRA_RG_SA) & ~prot_r;
wire sa_w = act_w & (rg_w == `OMRA_RG_SA) & ~prot_w;
// write is oldest, then read, then fetch; other regions never wait
wire g_w = act_w;
wire g_r = act_r & ~(sa_r & sa_w & (dr_addr_i[10] == dw_addr_i[10]));
wire g_f = act_f & ~(sa_f & sa_w & (pf_addr_i[10] == dw_addr_i[10]))
                 & ~(sa_f & sa_r & (pf_addr_i[10] == dr_addr_i[10]));
wire [2:0] grant = {g_w, g_r, g_f};
wire [2:0] remain = {act_w, act_r, act_f} & ~grant;
wire nr_next = |remain;

// served set accumulates while the core is held
always @* begin
    if (nr_next)
        done_next = done_reg | grant;
    else
        done_next = 3'h0;
end

// ---------------------------------------------------------------
// core side answers and sequencing
// ---------------------------------------------------------------
// read data from the pre-edge contents: write of the older instruction
// to the same dual-access word is seen by the next read, not this one
always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        done_reg <= 3'h0;
        not_ready_o <= 1'b0;
        pf_data_o <= 16'h0000;
        dr_data_o <= 16'h0000;
        ext_prog_sel_o <= 1'b0;
        ext_data_sel_o <= 1'b0;
        io_sel_o <= 1'b0;
        global_sel_o <= 1'b0;
    end else begin
        done_reg <= done_next;
        not_ready_o <= nr_next;
        if (g_f)
            pf_data_o <= rdw(rg_f, pf_addr_i);
        if (g_r)
            dr_data_o <= prot_r ? 16'h0000 : rdw(rg_r, dr_addr_i);
        ext_prog_sel_o <= g_f & (rg_f == `OMRA_RG_EXT);
        ext_data_sel_o <= (g_r & (rg_r == `OMRA_RG_EXT)) |
                          (g_w & (rg_w == `OMRA_RG_EXT));
        io_sel_o <= (g_r & (rg_r == `OMRA_RG_IO)) |
                    (g_w & (rg_w == `OMRA_RG_IO));
        global_sel_o <= (g_r & (rg_r == `OMRA_RG_GLB)) |
                        (g_w & (rg_w == `OMRA_RG_GLB));
    end
end

// operand writes into on-chip storage
always @(posedge sys_clk_i) begin
    if (g_w && !prot_w) begin
        case (rg_w)
            `OMRA_RG_MMR: mmr_mem[dw_addr_i[6:0]] <= dw_data_i;
            `OMRA_RG_B0: b0_mem[dw_addr_i[8:0]] <= dw_data_i;
            `OMRA_RG_B1: b1_mem[dw_addr_i[8:0]] <= dw_data_i;
            `OMRA_RG_B2: b2_mem[dw_addr_i[4:0]] <= dw_data_i;
            `OMRA_RG_SA: sa_mem[dw_addr_i[10:0]] <= dw_data_i;
            default: ;
        endcase
    end
end

// ---------------------------------------------------------------
// mode control, strap capture and apb slave
// ---------------------------------------------------------------
wire apb_setup = psel & ~penable & ~pready;
wire apb_wr = psel & penable & pready & pwrite;
wire ctrl_hit = (paddr == `OMRA_CTRL_OFF);
wire stat_hit = (paddr == `OMRA_STAT_OFF);
wire mmr_ctrl_wr = g_w & ~prot_w & (rg_w == `OMRA_RG_MMR) &
                   (dw_addr_i[6:0] == `OMRA_PROCESSOR_MODE_STATUS_REG_IDX);
wire viol_evt = (g_r & prot_r) | (g_w & prot_w);
wire [31:0] stat_word = {28'h0000000, strap_reg, viol_reg,
                         ~ctrl_reg[`OMRA_CTRL_MP], not_ready_o};

// microprocessor mode bit follows the strap once, then software
always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        ctrl_reg <= `OMRA_CTRL_RESET;
        strap_done_reg <= 1'b0;
        strap_reg <= 1'b0;
        viol_reg <= 1'b0;
        boot_from_ext_o <= 1'b0;
    end else begin
        if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            strap_reg <= microprocessor_mode_select_i;
            ctrl_reg[`OMRA_CTRL_MP] <= microprocessor_mode_select_i;
            boot_from_ext_o <= microprocessor_mode_select_i;
        end else if (apb_wr && ctrl_hit) begin
            ctrl_reg <= pwdata[4:0];
        end else if (mmr_ctrl_wr) begin
            ctrl_reg <= dw_data_i[4:0];
        end
        // sticky violation, a new event beats the clear
        if (viol_evt)
            viol_reg <= 1'b1;
        else if (apb_wr && stat_hit && pwdata[`OMRA_STAT_VIOL])
            viol_reg <= 1'b0;
    end
end

// zero-wait apb answer, data latched at the setup cycle
always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        pready <= 1'b0;
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
    end else begin
        pready <= apb_setup;
        if (apb_setup) begin
            pslverr <= ~(ctrl_hit | stat_hit);
            if (pwrite)
                prdata <= 32'h00000000;
            else if (ctrl_hit)
                prdata <= {27'h0000000, ctrl_reg};
            else if (stat_hit)
                prdata <= stat_word;
            else
                prdata <= 32'h00000000;
        end
    end
end

endmodule

//--- omra_mem_map_props.sv
/* Checker of the memory map block: stalls, decode and boot strap.
   Assumes it is bound to omra_mem_map and sees only its ports. */
`timescale 1ns/1ps
module omra_mem_map_props (
    // watched ports
    input wire sys_clk_i,
    input wire nrst_i,
    input wire pf_req_i,
    input wire [15:0] pf_addr_i,
    input wire dr_req_i,
    input wire [15:0] dr_addr_i,
    input wire [1:0] dr_space_i,
    input wire dw_req_i,
    input wire [15:0] dw_addr_i,
    input wire [1:0] dw_space_i,
    input wire not_ready_o,
    input wire ext_prog_sel_o,
    input wire ext_data_sel_o,
    input wire io_sel_o,
    input wire global_sel_o,
    input wire boot_from_ext_o
);
    // requests aimed at single-access blocks, two on one block
    wire p_sa = pf_req_i && pf_addr_i[15:11] == 5'h01;
    wire r_sa = dr_req_i && dr_space_i == 2'h0 && dr_addr_i[15:11] == 5'h01;
    wire w_sa = dw_req_i && dw_space_i == 2'h0 && dw_addr_i[15:11] == 5'h01;
    wire sa_multi = (p_sa && r_sa && pf_addr_i[10] == dr_addr_i[10]) ||
        (p_sa && w_sa && pf_addr_i[10] == dw_addr_i[10]) ||
        (r_sa && w_sa && dr_addr_i[10] == dw_addr_i[10]);
    reg [1:0] up_cnt;
    // edges since reset release, saturating at two
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h2) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_nr_bounded:
        assert property ($rose(not_ready_o) |-> ##[1:2] !not_ready_o)
        else $error("not-ready held too long");
    a_nr_cause:
        assert property ($rose(not_ready_o) |-> $past(sa_multi))
        else $error("not-ready without a block conflict");
    a_no_conflict:
        assert property (!not_ready_o && !sa_multi |=> !not_ready_o)
        else $error("stall without a conflict");
    a_io_offchip:
        assert property ($rose(dr_req_i) && dr_space_i == 2'h1 |=> io_sel_o)
        else $error("port read not sent off-chip");
    a_global_sel:
        assert property ($rose(dw_req_i) && dw_space_i == 2'h2 &&
            dw_addr_i[15] |=> global_sel_o)
        else $error("global write not selected");
    a_mmr_onchip:
        assert property ($rose(dr_req_i) && !dw_req_i && dr_space_i == 2'h0
            && dr_addr_i < 16'h0060 |=> !ext_data_sel_o && !not_ready_o)
        else $error("page zero word left the chip");
    a_ext_fetch:
        assert property ($rose(pf_req_i) && pf_addr_i[15:12] != 4'h0 &&
            pf_addr_i[15:12] != 4'hF |=> ext_prog_sel_o)
        else $error("off-chip fetch not selected");
    a_boot_hold:
        assert property (up_cnt == 2'h2 |-> $stable(boot_from_ext_o))
        else $error("boot strap changed after capture");
endmodule
bind omra_mem_map omra_mem_map_props omra_mem_map_props_i (.sys_clk_i,
    .nrst_i, .pf_req_i, .pf_addr_i, .dr_req_i, .dr_addr_i, .dr_space_i,
    .dw_req_i, .dw_addr_i, .dw_space_i, .not_ready_o, .ext_prog_sel_o,
    .ext_data_sel_o, .io_sel_o, .global_sel_o, .boot_from_ext_o);

//--- omra_core_model.sv
/* Core side of the memory block: fetch, read and write requests.
   Assumes the bench calls issue at a rising clock edge. */
`timescale 1ns/1ps
module omra_core_model (
    // clock and stall
    input wire sys_clk_i,
    input wire not_ready_i,
    // requests
    output reg pf_req_o,
    output reg [15:0] pf_addr_o,
    output reg dr_req_o,
    output reg [15:0] dr_addr_o,
    output reg [1:0] dr_space_o,
    output reg dw_req_o,
    output reg [15:0] dw_addr_o,
    output reg [1:0] dw_space_o,
    output reg [15:0] dw_data_o,
    output reg ext_origin_o
);
    // idle bus at time zero
    initial begin
        {pf_req_o, pf_addr_o, dr_req_o, dr_addr_o, dr_space_o} = 36'h0;
        {dw_req_o, dw_addr_o, dw_space_o, dw_data_o, ext_origin_o} = 36'h0;
    end
    // one request set, held while stalled; n counts cycles taken
    task issue(input [2:0] en, input [15:0] pa, da, wa, wd,
        input [1:0] sp, input ex, output integer n);
        {pf_req_o, dr_req_o, dw_req_o} <= en;
        {pf_addr_o, dr_addr_o, dw_addr_o, dw_data_o} <= {pa, da, wa, wd};
        {dr_space_o, dw_space_o, ext_origin_o} <= {sp, sp, ex};
        n = 0;
        // look at not-ready once it has settled after each edge, so the
        // requests drop right after the edge that performed the last one
        do begin
            @(posedge sys_clk_i);
            #1 n = n + 1;
        end while (not_ready_i && n < 20);
        {pf_req_o, dr_req_o, dw_req_o} <= 3'h0;
        {pf_addr_o, dr_addr_o, dw_addr_o} <= ~{pf_addr_o, dr_addr_o, dw_addr_o};
        @(posedge sys_clk_i);
    endtask
endmodule

//--- tb_top.sv
/* Self-checking bench of the memory map block.
   Assumes the core model and the bound checker are compiled before it. */
`timescale 1ns/1ps
module tb_top;
    logic sys_clk_i, nrst_i, microprocessor_mode_select_i, err;
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0] sel;
    wire [31:0] prdata;
    wire [15:0] pf_data_o, dr_data_o, pf_addr_i, dr_addr_i, dw_addr_i;
    wire [15:0] dw_data_i;
    wire [1:0] dr_space_i, dw_space_i;
    wire pready, pslverr, not_ready_o, ext_prog_sel_o, ext_data_sel_o;
    wire io_sel_o, global_sel_o, boot_from_ext_o, pf_req_i, dr_req_i;
    wire dw_req_i, ext_origin_i;
    integer failures, cmp_count, n;
    omra_mem_map omra_mem_map_i (.sys_clk_i, .nrst_i,
        .microprocessor_mode_select_i, .pf_req_i, .pf_addr_i, .dr_req_i,
        .dr_addr_i, .dr_space_i, .dw_req_i, .dw_addr_i, .dw_space_i,
        .dw_data_i, .ext_origin_i, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pf_data_o, .dr_data_o,
        .not_ready_o, .ext_prog_sel_o, .ext_data_sel_o, .io_sel_o,
        .global_sel_o, .boot_from_ext_o);
    omra_core_model omra_core_model_i (.sys_clk_i, .not_ready_i(not_ready_o),
        .pf_req_o(pf_req_i), .pf_addr_o(pf_addr_i), .dr_req_o(dr_req_i),
        .dr_addr_o(dr_addr_i), .dr_space_o(dr_space_i), .dw_req_o(dw_req_i),
        .dw_addr_o(dw_addr_i), .dw_space_o(dw_space_i),
        .dw_data_o(dw_data_i), .ext_origin_o(ext_origin_i));
    // -----
    // shared tasks
    // -----
    // 25 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    task finish_test;
        if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string s, input [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task rst(input s);
        nrst_i <= 1'b0;
        microprocessor_mode_select_i <= s;
        repeat (10) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer k;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        @(posedge sys_clk_i);
    endtask
    // request set on the core side; sel holds the off-chip pulses
    task op(input [2:0] en, input [15:0] pa, da, wa, wd, input [1:0] sp,
        input ex);
        fork
            omra_core_model_i.issue(en, pa, da, wa, wd, sp, ex, n);
            begin
                @(posedge sys_clk_i);
                #1 sel = {ext_prog_sel_o, ext_data_sel_o, io_sel_o, global_sel_o};
            end
        join
    endtask
    // -----
    // scenarios
    // -----
    task t_boot;
        rst(1'b0);
        chk("boot", 32'h0, boot_from_ext_o);
        op(3'h4, 16'h0010, 16'h0, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("rom", 32'h5A2C, pf_data_o);
        apb(1'b1, 12'h000, 32'h08);
        op(3'h4, 16'h0010, 16'h0, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("sel", 32'h8, sel);
        rst(1'b1);
        chk("boot", 32'h1, boot_from_ext_o);
        op(3'h4, 16'h0010, 16'h0, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("sel", 32'h8, sel);
    endtask
    task t_dual;
        op(3'h7, 16'h1000, 16'h0400, 16'h0060, 16'h1234, 2'h0, 1'b0);
        chk("cycles", 32'h1, n);
        op(3'h3, 16'h0, 16'h0400, 16'h0400, 16'hBEEF, 2'h0, 1'b0);
        chk("cycles", 32'h1, n);
        op(3'h2, 16'h0, 16'h0400, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("b1", 32'hBEEF, dr_data_o);
        op(3'h2, 16'h0, 16'h0060, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("b2", 32'h1234, dr_data_o);
    endtask
    task t_b0;
        op(3'h1, 16'h0, 16'h0, 16'h03FF, 16'h0B0B, 2'h0, 1'b0);
        apb(1'b1, 12'h000, 32'h09);
        op(3'h4, 16'hFFFF, 16'h0, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("b0", 32'h0B0B, pf_data_o);
        op(3'h2, 16'h0, 16'h03FF, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("sel", 32'h4, sel);
        apb(1'b1, 12'h000, 32'h08);
        op(3'h1, 16'h0, 16'h0, 16'h005F, 16'h00AA, 2'h0, 1'b0);
        op(3'h2, 16'h0, 16'h005F, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("mmr", 32'h00AA, dr_data_o);
        op(3'h2, 16'h0, 16'h0007, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("ctrl", 32'h0008, dr_data_o);
    endtask
    task t_sa;
        apb(1'b1, 12'h000, 32'h0C);
        op(3'h7, 16'h0800, 16'h0800, 16'h0800, 16'h5555, 2'h0, 1'b0);
        chk("cycles", 32'h3, n);
        chk("rd", 32'h5555, dr_data_o);
        chk("pf", 32'h5555, pf_data_o);
        op(3'h6, 16'h0C00, 16'h0C00, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("cycles", 32'h2, n);
        op(3'h3, 16'h0, 16'h0800, 16'h0C00, 16'h0001, 2'h0, 1'b0);
        chk("cycles", 32'h1, n);
        apb(1'b1, 12'h000, 32'h0A);
        op(3'h2, 16'h0, 16'h0800, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("sel", 32'h4, sel);
    endtask
    task t_prot;
        apb(1'b1, 12'h000, 32'h18);
        op(3'h1, 16'h0, 16'h0, 16'h0400, 16'h0, 2'h0, 1'b1);
        op(3'h2, 16'h0, 16'h0400, 16'h0, 16'h0, 2'h0, 1'b1);
        chk("prot", 32'h0, dr_data_o);
        op(3'h2, 16'h0, 16'h0400, 16'h0, 16'h0, 2'h0, 1'b0);
        chk("b1", 32'hBEEF, dr_data_o);
        op(3'h2, 16'h0, 16'h0005, 16'h0, 16'h0, 2'h1, 1'b0);
        chk("sel", 32'h2, sel);
        op(3'h1, 16'h0, 16'h0, 16'h8000, 16'h0, 2'h2, 1'b0);
        chk("sel", 32'h1, sel);
        apb(1'b0, 12'h008, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl_rd", 32'h18, rd);
        apb(1'b0, 12'h004, 32'h0);
        chk("stat", 32'hC, rd);
        apb(1'b1, 12'h004, 32'h4);
        apb(1'b0, 12'h004, 32'h0);
        chk("stat_clr", 32'h8, rd);
    endtask
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
        {nrst_i, microprocessor_mode_select_i} = 2'h0;
        failures = 0;
        cmp_count = 0;
        t_boot;
        t_dual;
        t_b0;
        t_sa;
        t_prot;
        finish_test;
    end
    // watchdog against a hang
    initial begin
        #400000;
        failures++;
        finish_test;
    end
endmodule
